/* File: rsb_alu.sv */
// Purpose: Combinational result and flag computation for rotate and subtract.
// Assumes: Flag byte in the layout of the constants header.
// Notes: Flags the operation leaves alone pass straight through.
`include "rsb_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module rsb_alu
	import rsb_pkg::*;
(
	// Operation and operands
	input  wire rsb_alu_op_t alu_op,
	input  wire logic [7:0]  dst_val,
	input  wire logic [7:0]  src_val,
	input  wire logic [7:0]  flags_in,
	// Results
	output logic      [7:0]  result,
	output logic      [7:0]  flags_out
);

	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] src_inv;
	logic       borrow_in;

	always_comb begin
		src_inv   = ~src_val;
		borrow_in = flags_in[`RSB_FLAG_C];
		// Adding the complement plus the inverted carry equals dst - src - carry.
		sum       = {1'b0, dst_val} + {1'b0, src_inv} + {8'h00, ~borrow_in};
		low_sum   = {1'b0, dst_val[3:0]} + {1'b0, src_inv[3:0]} + {4'h0, ~borrow_in};
		flags_out = flags_in;
		if (alu_op == ALU_ROT) begin
			result                 = {borrow_in, dst_val[7:1]};
			flags_out[`RSB_FLAG_C] = dst_val[0];
			flags_out[`RSB_FLAG_Z] = (result == `RSB_BYTE_ZERO);
			flags_out[`RSB_FLAG_S] = result[7];
			flags_out[`RSB_FLAG_V] = result[7] ^ dst_val[7];
		end else begin
			result                 = sum[7:0];
			flags_out[`RSB_FLAG_C] = ~sum[8];
			flags_out[`RSB_FLAG_Z] = (result == `RSB_BYTE_ZERO);
			flags_out[`RSB_FLAG_S] = result[7];
			flags_out[`RSB_FLAG_V] = (dst_val[7] != src_val[7]) && (result[7] == src_val[7]);
			flags_out[`RSB_FLAG_D] = 1'b1;
			flags_out[`RSB_FLAG_H] = ~low_sum[4];
		end
	end

endmodule

`default_nettype wire

/* File: rsb_consts.svh */
// Purpose: Shared constants for the rotate, bank select and subtract-with-borrow datapath.
// Assumes: Flag byte layout C,Z,S,V,D,H,FS,BA from bit 7 down to bit 0.
// Notes: Cycle limits are instruction length in cycles minus one.
`ifndef RSB_CONSTS_SVH
`define RSB_CONSTS_SVH

`define RSB_OP_ROT_DIR   8'hc0
`define RSB_OP_ROT_IND   8'hc1
`define RSB_OP_BANK0     8'h4f
`define RSB_OP_BANK1     8'h5f
`define RSB_OP_SUBB_WW   8'h32
`define RSB_OP_SUBB_WI   8'h33
`define RSB_OP_SUBB_RR   8'h34
`define RSB_OP_SUBB_RI   8'h35
`define RSB_OP_SUBB_IM   8'h36

`define RSB_FLAG_C       7
`define RSB_FLAG_Z       6
`define RSB_FLAG_S       5
`define RSB_FLAG_V       4
`define RSB_FLAG_D       3
`define RSB_FLAG_H       2
`define RSB_FLAG_BA      0
`define RSB_FLAGS_RESET  8'h00

`define RSB_LAST_4       3'h3
`define RSB_LAST_6       3'h5
`define RSB_CNT_ONE      3'h1
`define RSB_CNT_RESET    3'h0

`define RSB_LEN_1        2'h1
`define RSB_LEN_2        2'h2
`define RSB_LEN_3        2'h3
`define RSB_LEN_RESET    2'h0

`define RSB_BYTE_ZERO    8'h00

`endif

/* File: rsb_core.sv */
// Purpose: Sequencer for rotate-through-carry, bank select and subtract-with-borrow.
// Assumes: Register file read data follows rf_raddr in the same cycle.
// Notes: Instructions are accepted only while ready is high.
`include "rsb_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module rsb_core
	import rsb_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// Instruction from decode
	input  wire logic       start,
	input  wire logic [7:0] opcode,
	input  wire logic [7:0] op_byte1,
	input  wire logic [7:0] op_byte2,
	input  wire logic [3:0] working_base,
	output logic            ready,
	output logic            done,
	output logic            illegal,
	output logic      [1:0] instr_len,
	// Register file
	output logic      [7:0] rf_raddr,
	input  wire logic [7:0] rf_rdata,
	output logic            rf_we,
	output logic      [7:0] rf_waddr,
	output logic      [7:0] rf_wdata,
	// Flag register
	input  wire logic       flags_load,
	input  wire logic [7:0] flags_load_data,
	output logic      [7:0] flags_out,
	output logic            bank_sel
);

	rsb_state_t  state_reg,    state_next;
	rsb_kind_t   kind_reg,     kind_next;
	logic        imm_reg,      imm_next;
	logic [2:0]  cnt_reg,      cnt_next;
	logic [2:0]  last_reg,     last_next;
	logic [1:0]  len_reg,      len_next;
	logic [7:0]  dst_addr_reg, dst_addr_next;
	logic [7:0]  src_addr_reg, src_addr_next;
	logic [7:0]  dst_val_reg,  dst_val_next;
	logic [7:0]  result_reg,   result_next;
	logic [7:0]  raddr_reg,    raddr_next;
	logic [7:0]  flags_reg,    flags_next;

	rsb_kind_t   dec_kind;
	logic        dec_ind;
	logic        dec_imm;
	logic [2:0]  dec_last;
	logic [1:0]  dec_len;
	logic [7:0]  dec_dst;
	logic [7:0]  dec_src;
	rsb_alu_op_t alu_op;
	logic [7:0]  alu_dst;
	logic [7:0]  alu_src;
	logic [7:0]  alu_result;
	logic [7:0]  alu_flags;
	logic        accept;

	// Address fields: for indirect forms dec_dst or dec_src holds the pointer register.
	always_comb begin
		dec_kind = K_NONE;
		dec_ind  = 1'b0;
		dec_imm  = 1'b0;
		dec_last = `RSB_LAST_4;
		dec_len  = `RSB_LEN_2;
		dec_dst  = op_byte1;
		dec_src  = op_byte2;
		case (opcode)
			`RSB_OP_ROT_DIR: begin
				dec_kind = K_ROT;
			end
			`RSB_OP_ROT_IND: begin
				dec_kind = K_ROT;
				dec_ind  = 1'b1;
			end
			`RSB_OP_BANK0: begin
				dec_kind = K_BANK0;
				dec_len  = `RSB_LEN_1;
			end
			`RSB_OP_BANK1: begin
				dec_kind = K_BANK1;
				dec_len  = `RSB_LEN_1;
			end
			`RSB_OP_SUBB_WW, `RSB_OP_SUBB_WI: begin
				dec_kind = K_SUBB;
				dec_ind  = (opcode == `RSB_OP_SUBB_WI);
				dec_last = dec_ind ? `RSB_LAST_6 : `RSB_LAST_4;
				dec_dst  = {working_base, op_byte1[7:4]};
				dec_src  = {working_base, op_byte1[3:0]};
			end
			`RSB_OP_SUBB_RR, `RSB_OP_SUBB_RI: begin
				// Source byte comes first in these encodings.
				dec_kind = K_SUBB;
				dec_ind  = (opcode == `RSB_OP_SUBB_RI);
				dec_last = `RSB_LAST_6;
				dec_len  = `RSB_LEN_3;
				dec_dst  = op_byte2;
				dec_src  = op_byte1;
			end
			`RSB_OP_SUBB_IM: begin
				dec_kind = K_SUBB;
				dec_imm  = 1'b1;
				dec_last = `RSB_LAST_6;
				dec_len  = `RSB_LEN_3;
			end
			default: begin
				dec_kind = K_NONE;
			end
		endcase
	end

	assign accept = start && (state_reg == ST_IDLE);

	// The destination is taken straight off the read port so a rotate needs no extra cycle.
	always_comb begin
		alu_op  = (kind_reg == K_ROT) ? ALU_ROT : ALU_SUBB;
		alu_dst = (state_reg == ST_DST) ? rf_rdata : dst_val_reg;
		alu_src = imm_reg ? src_addr_reg : rf_rdata;
	end

	rsb_alu u_alu (
		.alu_op    (alu_op),
		.dst_val   (alu_dst),
		.src_val   (alu_src),
		.flags_in  (flags_reg),
		.result    (alu_result),
		.flags_out (alu_flags)
	);

	always_comb begin
		state_next    = state_reg;
		kind_next     = kind_reg;
		imm_next      = imm_reg;
		last_next     = last_reg;
		len_next      = len_reg;
		dst_addr_next = dst_addr_reg;
		src_addr_next = src_addr_reg;
		dst_val_next  = dst_val_reg;
		result_next   = result_reg;
		raddr_next    = raddr_reg;
		cnt_next      = 3'(cnt_reg + `RSB_CNT_ONE);
		done          = 1'b0;
		illegal       = 1'b0;
		// An instruction's own flag update overrides a load in the same cycle.
		flags_next    = flags_load ? flags_load_data : flags_reg;
		case (state_reg)
			ST_IDLE: begin
				cnt_next = `RSB_CNT_ONE;
				if (start && dec_kind == K_NONE) begin
					illegal = 1'b1;
				end else if (start) begin
					kind_next     = dec_kind;
					imm_next      = dec_imm;
					last_next     = dec_last;
					len_next      = dec_len;
					dst_addr_next = dec_dst;
					src_addr_next = dec_src;
					if (dec_kind == K_BANK0 || dec_kind == K_BANK1) begin
						state_next = ST_BANK;
					end else if (dec_ind) begin
						state_next = ST_PTR;
						raddr_next = (dec_kind == K_ROT) ? dec_dst : dec_src;
					end else begin
						state_next = ST_DST;
						raddr_next = dec_dst;
					end
				end
			end
			ST_PTR: begin
				// The pointer's contents replace the register address it stood for.
				if (kind_reg == K_ROT) begin
					dst_addr_next = rf_rdata;
					raddr_next    = rf_rdata;
				end else begin
					src_addr_next = rf_rdata;
					raddr_next    = dst_addr_reg;
				end
				state_next = ST_DST;
			end
			ST_DST: begin
				if (kind_reg == K_ROT) begin
					result_next = alu_result;
					flags_next  = alu_flags;
					state_next  = ST_WB;
				end else begin
					dst_val_next = rf_rdata;
					raddr_next   = src_addr_reg;
					state_next   = ST_SRC;
				end
			end
			ST_SRC: begin
				result_next = alu_result;
				flags_next  = alu_flags;
				state_next  = ST_WB;
			end
			ST_BANK: begin
				flags_next              = flags_reg;
				flags_next[`RSB_FLAG_BA] = (kind_reg == K_BANK1);
				state_next              = ST_PAD;
			end
			ST_WB, ST_PAD: begin
				if (cnt_reg == last_reg) begin
					done       = 1'b1;
					state_next = ST_IDLE;
				end else begin
					state_next = ST_PAD;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= ST_IDLE;
			kind_reg     <= K_NONE;
			imm_reg      <= 1'b0;
			cnt_reg      <= `RSB_CNT_RESET;
			last_reg     <= `RSB_LAST_4;
			len_reg      <= `RSB_LEN_RESET;
			dst_addr_reg <= `RSB_BYTE_ZERO;
			src_addr_reg <= `RSB_BYTE_ZERO;
			dst_val_reg  <= `RSB_BYTE_ZERO;
			result_reg   <= `RSB_BYTE_ZERO;
			raddr_reg    <= `RSB_BYTE_ZERO;
			flags_reg    <= `RSB_FLAGS_RESET;
		end else begin
			state_reg    <= state_next;
			kind_reg     <= kind_next;
			imm_reg      <= imm_next;
			cnt_reg      <= cnt_next;
			last_reg     <= last_next;
			len_reg      <= len_next;
			dst_addr_reg <= dst_addr_next;
			src_addr_reg <= src_addr_next;
			dst_val_reg  <= dst_val_next;
			result_reg   <= result_next;
			raddr_reg    <= raddr_next;
			flags_reg    <= flags_next;
		end
	end

	assign ready     = (state_reg == ST_IDLE);
	assign instr_len = len_reg;
	assign rf_raddr  = raddr_reg;
	assign rf_we     = (state_reg == ST_WB);
	assign rf_waddr  = dst_addr_reg;
	assign rf_wdata  = result_reg;
	assign flags_out = flags_reg;
	assign bank_sel  = flags_reg[`RSB_FLAG_BA];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	logic rot_exec;
	logic sub_exec;
	assign rot_exec = (state_reg == ST_DST) && (kind_reg == K_ROT);
	assign sub_exec = (state_reg == ST_SRC);

	property p_rot_result;
		rot_exec |=> result_reg == {$past(flags_reg[`RSB_FLAG_C]), $past(rf_rdata[7:1])}
			&& flags_reg[`RSB_FLAG_C] == $past(rf_rdata[0]);
	endproperty
	a_rot_result: assert property (p_rot_result) else $error("rotate result or carry wrong");

	property p_rot_flags;
		rot_exec |=> flags_reg[`RSB_FLAG_Z] == (result_reg == `RSB_BYTE_ZERO)
			&& flags_reg[`RSB_FLAG_S] == result_reg[7]
			&& $stable(flags_reg[`RSB_FLAG_D]) && $stable(flags_reg[`RSB_FLAG_H]);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("rotate zero, sign or kept flags wrong");

	property p_rot_ovf;
		rot_exec |=> flags_reg[`RSB_FLAG_V] == (result_reg[7] ^ $past(rf_rdata[7]));
	endproperty
	a_rot_ovf: assert property (p_rot_ovf) else $error("rotate overflow wrong");

	property p_rot_time;
		accept && (opcode == `RSB_OP_ROT_DIR || opcode == `RSB_OP_ROT_IND)
			|-> !done [*3] ##1 done ##1 ready;
	endproperty
	a_rot_time: assert property (p_rot_time) else $error("rotate not done in four cycles");

	property p_bank0;
		accept && opcode == `RSB_OP_BANK0 && !flags_load |=> ##1 !bank_sel
			&& flags_reg[7:1] == $past(flags_reg[7:1], 2);
	endproperty
	a_bank0: assert property (p_bank0) else $error("bank zero select wrong");

	property p_bank1;
		accept && opcode == `RSB_OP_BANK1 && !flags_load |=> ##1 bank_sel
			&& flags_reg[7:1] == $past(flags_reg[7:1], 2);
	endproperty
	a_bank1: assert property (p_bank1) else $error("bank one select wrong");

	property p_sub_result;
		sub_exec |=> result_reg == 8'($past(dst_val_reg) - $past(alu_src)
			- {7'h00, $past(flags_reg[`RSB_FLAG_C])}) ##1 1'b1;
	endproperty
	a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

	property p_sub_carry;
		sub_exec |=> flags_reg[`RSB_FLAG_C] == (({1'b0, $past(alu_src)}
			+ {8'h00, $past(flags_reg[`RSB_FLAG_C])}) > {1'b0, $past(dst_val_reg)});
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("subtract borrow wrong");

	property p_sub_zs;
		sub_exec |=> flags_reg[`RSB_FLAG_Z] == (result_reg == `RSB_BYTE_ZERO)
			&& flags_reg[`RSB_FLAG_S] == result_reg[7];
	endproperty
	a_sub_zs: assert property (p_sub_zs) else $error("subtract zero or sign wrong");

	property p_sub_ovf;
		sub_exec |=> flags_reg[`RSB_FLAG_V] == (($past(dst_val_reg[7]) != $past(alu_src[7]))
			&& result_reg[7] == $past(alu_src[7]));
	endproperty
	a_sub_ovf: assert property (p_sub_ovf) else $error("subtract overflow wrong");

	property p_sub_dh;
		sub_exec |=> flags_reg[`RSB_FLAG_D] && flags_reg[`RSB_FLAG_H]
			== ($past(dst_val_reg[3:0]) < 4'($past(alu_src[3:0]) + {3'h0, $past(flags_reg[`RSB_FLAG_C])})
			|| ($past(alu_src[3:0]) == 4'hf && $past(flags_reg[`RSB_FLAG_C])));
	endproperty
	a_sub_dh: assert property (p_sub_dh) else $error("subtract decimal or half flag wrong");

	property p_sub_short;
		accept && opcode == `RSB_OP_SUBB_WW |-> ##3 done ##1 ready;
	endproperty
	a_sub_short: assert property (p_sub_short) else $error("short subtract timing wrong");

	property p_sub_long;
		accept && (opcode == `RSB_OP_SUBB_IM || opcode == `RSB_OP_SUBB_RI) |-> ##1 !done [*4] ##1 done;
	endproperty
	a_sub_long: assert property (p_sub_long) else $error("long subtract timing wrong");

	property p_ind_target;
		state_reg == ST_PTR && kind_reg == K_ROT |-> ##2 rf_we && rf_waddr == $past(rf_rdata, 2);
	endproperty
	a_ind_target: assert property (p_ind_target) else $error("indirect target address wrong");

	c_rot_ind: cover property (accept && opcode == `RSB_OP_ROT_IND ##3 done);
	c_sub_ind: cover property (accept && opcode == `RSB_OP_SUBB_WI ##5 done);
	c_bank1:   cover property (accept && opcode == `RSB_OP_BANK1 ##3 done);
	c_illegal: cover property (illegal);

endmodule

`default_nettype wire

/* File: rsb_core_test.sv */
// Purpose: Self-checking bench for the rotate, bank select and subtract sequencer.
// Assumes: Working registers sit at base 2, so r1 is 21h and r2 is 22h.
// Notes: Expected results are computed here from operand values.
`timescale 1ns/100ps
`default_nettype none

module rsb_core_test;
	logic       mclk, reset_n, start, ready, done, illegal, rf_we, flags_load, bank_sel;
	logic [7:0] opcode, op_byte1, op_byte2, rf_raddr, rf_rdata, rf_waddr, rf_wdata;
	logic [7:0] flags_load_data, flags_out;
	logic [3:0] working_base;
	logic [1:0] instr_len;
	int         fail_count, compares;

	rsb_core dut (.mclk(mclk), .reset_n(reset_n), .start(start), .opcode(opcode), .op_byte1(op_byte1),
		.op_byte2(op_byte2), .working_base(working_base), .ready(ready), .done(done), .illegal(illegal),
		.instr_len(instr_len), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we),
		.rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .flags_load(flags_load),
		.flags_load_data(flags_load_data), .flags_out(flags_out), .bank_sel(bank_sel));

	rsb_rf_model rf (.mclk(mclk), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we),
		.rf_waddr(rf_waddr), .rf_wdata(rf_wdata));

	always #20 mclk = ~mclk;

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic set_flags(input logic [7:0] f);
		@(negedge mclk);
		flags_load      = 1'b1;
		flags_load_data = f;
		@(negedge mclk);
		flags_load      = 1'b0;
	endtask

	// Issues one instruction and measures the cycle in which done appears.
	task automatic run_op(input logic [7:0] opc, b1, b2, input int cyc, input logic [1:0] len);
		int n;
		@(negedge mclk);
		start    = 1'b1;
		opcode   = opc;
		op_byte1 = b1;
		op_byte2 = b2;
		@(negedge mclk);
		start = 1'b0;
		n = 1;
		chk("ready busy", 8'h00, {7'h00, ready});
		while (done !== 1'b1) begin
			if (n > 8) begin
				chk("done wait", 8'h01, 8'h00);
				report_and_stop();
			end
			@(negedge mclk);
			n++;
		end
		chk("done cycle", 8'(cyc - 1), 8'(n));
		chk("instr_len", {6'h00, len}, {6'h00, instr_len});
		@(negedge mclk);
		chk("ready again", 8'h01, {7'h00, ready});
	endtask

	task automatic rot_case(input logic [7:0] opc, b1, ta, d, f);
		logic [7:0] r;
		r = {f[7], d[7:1]};
		rf.mem[ta] = d;
		set_flags(f);
		run_op(opc, b1, 8'h00, 4, 2'h2);
		chk("rotate result", r, rf.mem[ta]);
		chk("rotate flags", {d[0], r == 8'h00, r[7], d[7] ^ r[7], f[3:0]}, flags_out);
	endtask

	task automatic sbc_case(input logic [7:0] opc, b1, b2, input int cyc, input logic [1:0] len,
		input logic [7:0] da, d, sa, s, f, input logic imm);
		logic [8:0] diff;
		logic [4:0] lo;
		diff = {1'b0, d} - {1'b0, s} - {8'h00, f[7]};
		lo   = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, f[7]};
		if (!imm) begin
			rf.mem[sa] = s;
		end
		rf.mem[da] = d;
		set_flags(f);
		run_op(opc, b1, b2, cyc, len);
		chk("subtract result", diff[7:0], rf.mem[da]);
		chk("subtract flags", {diff[8], diff[7:0] == 8'h00, diff[7], (d[7] ^ s[7]) & ~(diff[7] ^ s[7]),
			1'b1, lo[4], f[1:0]}, flags_out);
		if (!imm) begin
			chk("source kept", s, rf.mem[sa]);
		end
	endtask

	task automatic bank_case(input logic [7:0] opc, f, input logic bit0);
		set_flags(f);
		run_op(opc, 8'h00, 8'h00, 4, 2'h1);
		chk("bank flags", {f[7:1], bit0}, flags_out);
		chk("bank select", {7'h00, bit0}, {7'h00, bank_sel});
	endtask

	task automatic illegal_case();
		@(negedge mclk);
		start  = 1'b1;
		opcode = 8'h00;
		#5;
		chk("illegal pulse", 8'h01, {7'h00, illegal});
		@(negedge mclk);
		start = 1'b0;
		chk("idle after illegal", 8'h01, {7'h00, ready});
	endtask

	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		start = 1'b0;
		opcode = 8'h00;
		op_byte1 = 8'h00;
		op_byte2 = 8'h00;
		working_base = 4'h2;
		flags_load = 1'b0;
		flags_load_data = 8'h00;
		fail_count = 0;
		compares = 0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("reset flags", 8'h00, flags_out);
		chk("reset len", 8'h00, {6'h00, instr_len});
		reset_n = 1'b1;
		rot_case(8'hc0, 8'h20, 8'h20, 8'h55, 8'h0d);
		rot_case(8'hc0, 8'h20, 8'h20, 8'h01, 8'h80);
		rot_case(8'hc0, 8'h30, 8'h30, 8'h01, 8'h06);
		rf.mem[8'h41] = 8'h50;
		rot_case(8'hc1, 8'h41, 8'h50, 8'h17, 8'h00);
		bank_case(8'h5f, 8'hfe, 1'b1);
		bank_case(8'h4f, 8'hff, 1'b0);
		sbc_case(8'h32, 8'h12, 8'h00, 4, 2'h2, 8'h21, 8'h10, 8'h22, 8'h03, 8'h80, 1'b0);
		sbc_case(8'h32, 8'h12, 8'h00, 4, 2'h2, 8'h21, 8'h00, 8'h22, 8'h00, 8'h80, 1'b0);
		rf.mem[8'h22] = 8'h03;
		sbc_case(8'h33, 8'h12, 8'h00, 6, 2'h2, 8'h21, 8'h10, 8'h03, 8'h0a, 8'h81, 1'b0);
		sbc_case(8'h34, 8'h02, 8'h01, 6, 2'h3, 8'h01, 8'h20, 8'h02, 8'h03, 8'h80, 1'b0);
		rf.mem[8'h02] = 8'h03;
		sbc_case(8'h35, 8'h02, 8'h01, 6, 2'h3, 8'h01, 8'h20, 8'h03, 8'h0a, 8'h80, 1'b0);
		sbc_case(8'h36, 8'h01, 8'h8a, 6, 2'h3, 8'h01, 8'h20, 8'h00, 8'h8a, 8'h80, 1'b1);
		sbc_case(8'h36, 8'h01, 8'h01, 6, 2'h3, 8'h01, 8'h80, 8'h00, 8'h01, 8'h00, 1'b1);
		illegal_case();
		report_and_stop();
	end
endmodule

`default_nettype wire

/* File: rsb_pkg.sv */
// Purpose: Types for the rotate, bank select and subtract-with-borrow datapath.
// Assumes: Nothing beyond the constants header.
// Notes: Enumerations carry no explicit codes.
`default_nettype none

package rsb_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PTR,
		ST_DST,
		ST_SRC,
		ST_BANK,
		ST_WB,
		ST_PAD
	} rsb_state_t;

	typedef enum logic [2:0] {
		K_NONE,
		K_ROT,
		K_SUBB,
		K_BANK0,
		K_BANK1
	} rsb_kind_t;

	typedef enum logic {
		ALU_ROT,
		ALU_SUBB
	} rsb_alu_op_t;

endpackage

`default_nettype wire

/* File: rsb_rf_model.sv */
// Purpose: Register file standing on the far side of the sequencer.
// Assumes: Read data follows the read address in the same cycle.
// Notes: The bench preloads and inspects the array by name.
`timescale 1ns/100ps
`default_nettype none

module rsb_rf_model (
	// Clock
	input  wire logic       mclk,
	// Read port
	input  wire logic [7:0] rf_raddr,
	output logic      [7:0] rf_rdata,
	// Write port
	input  wire logic       rf_we,
	input  wire logic [7:0] rf_waddr,
	input  wire logic [7:0] rf_wdata
);
	logic [7:0] mem [256];

	// Left unset cells stay unknown, so a read of a wrong address cannot pass by luck.
	assign rf_rdata = mem[rf_raddr];

	always @(posedge mclk) begin
		if (rf_we) begin
			mem[rf_waddr] <= rf_wdata;
		end
	end
endmodule

`default_nettype wire
